// file: dv/vir_core_model.sv
// Core model that services GPIO edge requests after a delay
`timescale 1ns/1ps
module vir_core_model #(parameter int LAT = 3) (
  // Clock
  input wire logic core_clk,
  // Requests from the router
  input wire logic irq_req,
  input wire logic [5:0] irq_source,
  input wire logic ack_en,
  // Edge acknowledge
  output logic [18:0] gpio_ack
);
  int wcnt = 0;
  logic [18:0] ack_v;
  initial gpio_ack = '0;
  // Slow service keeps the edge latch visible for a few cycles
  // The pulse is built aside so the pins change only once per step
  always begin
    @(posedge core_clk);
    #1;
    ack_v = '0;
    if (ack_en && irq_req && irq_source < 6'h13) begin
      if (wcnt == LAT) begin
        ack_v[irq_source] = 1'b1;
        wcnt = 0;
      end else begin
        wcnt++;
      end
    end else begin
      wcnt = 0;
    end
    gpio_ack = ack_v;
  end
endmodule

// file: dv/vir_top_tb.sv
// Self-checking bench for the vectored interrupt router
`timescale 1ns/1ps
module vir_top_tb;
  logic core_clk, nrst, ack_en, irq_req, fast_req, fast_high;
  logic [53:0] periph_irq, src_enable, src_active_low, route_fast, fast_prio_hi;
  logic [18:0] gpio_in, gpio_int_en, gpio_ack, gpio_edge_pending;
  logic [18:0][2:0] gpio_mode;
  logic [2:0] ext_irq;
  logic [5:0] irq_mask_level, irq_source, fast_source;
  logic [1:0] fast_mask_level;
  logic [4:0] irq_vector;
  int mismatches = 0;
  int n_tests = 0;
  int seed = 40;
  int er, es, ef, efh, efs;
  vir_top dut (.core_clk(core_clk), .nrst(nrst), .periph_irq(periph_irq), .ext_irq(ext_irq),
    .gpio_in(gpio_in), .src_enable(src_enable), .src_active_low(src_active_low), .route_fast(route_fast),
    .fast_prio_hi(fast_prio_hi), .gpio_int_en(gpio_int_en), .gpio_mode(gpio_mode), .gpio_ack(gpio_ack),
    .irq_mask_level(irq_mask_level), .fast_mask_level(fast_mask_level), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_source(irq_source), .fast_interrupt_request(fast_req),
    .fast_high(fast_high), .fast_source(fast_source), .gpio_edge_pending(gpio_edge_pending));
  vir_core_model core (.core_clk(core_clk), .irq_req(irq_req), .irq_source(irq_source),
    .ack_en(ack_en), .gpio_ack(gpio_ack));
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Reference for internal sources only; GPIO and external slots are idle then
  function automatic void ref_out();
    er = 0; es = 0; ef = 0; efh = 0; efs = 0;
    for (int s = 53; s > 18; s--) begin
      if (s != 22 && s != 33 && s != 40 && src_enable[s] && (periph_irq[s] ^ src_active_low[s])) begin
        if (!route_fast[s] && (s > 31 ? 31 : s) < irq_mask_level) begin
          er = 1;
          es = s;
        end
        if (route_fast[s] && (fast_mask_level > 1 || (fast_mask_level == 1 && fast_prio_hi[s]))
            && (fast_prio_hi[s] || !efh)) begin
          ef = 1;
          efh = fast_prio_hi[s];
          efs = s;
        end
      end
    end
  endfunction
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {nrst, ack_en, periph_irq, src_enable, src_active_low, route_fast, fast_prio_hi} = '0;
    {gpio_in, gpio_int_en, gpio_mode, ext_irq, irq_mask_level, fast_mask_level} = '0;
    ref_out();
    tick(20);
    nrst = 1;
    repeat (600) begin
      tick(1);
      chk(8'(irq_req), 8'(er));
      if (er) chk(8'(irq_source), 8'(es));
      if (er) chk(8'(irq_vector), 8'(es > 31 ? 31 : es));
      chk(8'(fast_req), 8'(ef));
      if (ef) chk({fast_high, 1'b0, fast_source}, 8'(efh * 128 + efs));
      periph_irq = 54'({$random(seed), $random(seed)});
      src_enable = 54'({$random(seed), $random(seed)} & {$random(seed), $random(seed)});
      src_active_low = 54'({$random(seed), $random(seed)});
      route_fast = 54'({$random(seed), $random(seed)});
      fast_prio_hi = 54'({$random(seed), $random(seed)});
      irq_mask_level = 6'({$random(seed)} % 33);
      fast_mask_level = 2'($random(seed));
      ref_out();
    end
    $display("random routing test done");
    {periph_irq, route_fast, src_active_low} = '0;
    src_enable = '1;
    irq_mask_level = 6'h20;
    for (int i = 0; i < 3; i++) begin
      ext_irq = 3'(1 << i);
      tick(3);
      chk(8'(irq_req), 8'h01);
      chk(8'(irq_source), 8'(vir_pkg::EXT_IDX[i]));
      ext_irq = '0;
      tick(3);
      chk(8'(irq_req), 8'h00);
    end
    // Inverted polarity on an idle internal line must raise a request
    src_active_low[19] = 1'b1;
    tick(1);
    chk(8'(irq_req), 8'h01);
    chk(8'(irq_source), 8'h13);
    chk(8'(irq_vector), 8'h13);
    src_active_low[19] = 1'b0;
    $display("external line test done");
    src_enable = 54'h8;
    gpio_int_en = 19'h8;
    ack_en = 1;
    // Slow core acks edges between checks, so each phase starts clean
    for (int m = 0; m < 5; m++) begin
      gpio_mode[3] = 3'(m);
      tick(8);
      gpio_in[3] = 1;
      tick(4);
      chk(8'(irq_req), 8'(m == 0 || m == 2 || m == 4));
      chk(8'(gpio_edge_pending[3]), 8'(m == 2 || m == 4));
      tick(8);
      gpio_in[3] = 0;
      tick(4);
      chk(8'(irq_req), 8'(m == 1 || m == 3 || m == 4));
      if (irq_req) chk(8'(irq_source), 8'h03);
      $display("gpio mode %0d test done", m);
    end
    tick(12);
    chk(8'(gpio_edge_pending[3]), 8'h00);
    print_verdict();
  end
endmodule

// file: hw/vir_pkg.sv
// Shared constants, types and helpers for the vectored interrupt router
package vir_pkg;
  localparam int NSRC = 54;
  localparam int SRCW = 6;
  localparam int NGPIO = 19;
  localparam int NEXT = 3;
  localparam int LVLW = 5;
  localparam int MASKW = 6;
  localparam int GPIO_BASE = 0;
  localparam int EXT_IDX [NEXT] = '{22, 33, 40};
  localparam logic [SRCW-1:0] LVL_MAX = 6'h1f;
  localparam logic [MASKW-1:0] IRQ_MASK_OPEN = 6'h20;
  localparam logic [1:0] FAST_MASK_HI = 2'h1;
  localparam logic [1:0] FAST_MASK_ALL = 2'h2;
  localparam logic [NSRC-1:0] SRC_RST = 54'h0;
  localparam logic [NGPIO-1:0] GPIO_RST = 19'h0;
  localparam logic [NEXT-1:0] EXT_RST = 3'h0;
  localparam logic [SRCW-1:0] IDX_RST = 6'h0;
  localparam logic [LVLW-1:0] LVL_RST = 5'h0;

  typedef enum logic [2:0] {
    VIR_LVL_HI,
    VIR_LVL_LO,
    VIR_RISE,
    VIR_FALL,
    VIR_BOTH
  } vir_gmode_t;

  // Sources above the last level share the lowest normal priority
  function automatic logic [LVLW-1:0] irq_level(input logic [SRCW-1:0] s);
    return (s > LVL_MAX) ? LVL_MAX[LVLW-1:0] : s[LVLW-1:0];
  endfunction
endpackage

// file: hw/vir_prio.sv
// Fixed priority encoder, lowest source number wins
`timescale 1ns/1ps
module vir_prio (
  // Request and winner
  vir_prio_if.enc p
);
  always_comb begin
    p.idx = vir_pkg::IDX_RST;
    p.hit = 1'b0;
    for (int i = vir_pkg::NSRC - 1; i >= 0; i--) begin
      if (p.req[i]) begin
        p.idx = i[vir_pkg::SRCW-1:0];
        p.hit = 1'b1;
      end
    end
  end
endmodule

// file: hw/vir_prio_if.sv
// Request vector and winner between the router and its priority encoder
`timescale 1ns/1ps
interface vir_prio_if;
  logic [vir_pkg::NSRC-1:0] req;
  logic [vir_pkg::SRCW-1:0] idx;
  logic hit;
  modport enc (input req, output idx, output hit);
  modport user (output req, input idx, input hit);
endinterface

// file: hw/vir_top.sv
// Vectored interrupt router: source conditioning, routing, masking and priority
// Functional notes
// - 54 sources, each routed normal or fast
// - 32 normal levels, two fast levels
// - Internal sources level, programmable polarity
// - GPIO: high, low, rise, fall, both
// - Three external lines, active-high level
// - Any of 19 GPIO may interrupt
// - Priority mask withholds fast and normal
// - External lines sit at sources 22,33,40
`timescale 1ns/1ps
module vir_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Source inputs
  input wire logic [vir_pkg::NSRC-1:0] periph_irq,
  input wire logic [vir_pkg::NEXT-1:0] ext_irq,
  input wire logic [vir_pkg::NGPIO-1:0] gpio_in,
  // Source configuration
  input wire logic [vir_pkg::NSRC-1:0] src_enable,
  input wire logic [vir_pkg::NSRC-1:0] src_active_low,
  input wire logic [vir_pkg::NSRC-1:0] route_fast,
  input wire logic [vir_pkg::NSRC-1:0] fast_prio_hi,
  input wire logic [vir_pkg::NGPIO-1:0] gpio_int_en,
  input wire logic [vir_pkg::NGPIO-1:0][2:0] gpio_mode,
  input wire logic [vir_pkg::NGPIO-1:0] gpio_ack,
  // Priority masks
  input wire logic [vir_pkg::MASKW-1:0] irq_mask_level,
  input wire logic [1:0] fast_mask_level,
  // Requests to the core
  output logic irq_req,
  output logic [vir_pkg::LVLW-1:0] irq_vector,
  output logic [vir_pkg::SRCW-1:0] irq_source,
  output logic fast_interrupt_request,
  output logic fast_high,
  output logic [vir_pkg::SRCW-1:0] fast_source,
  // Status
  output logic [vir_pkg::NGPIO-1:0] gpio_edge_pending
);
  logic [vir_pkg::NEXT-1:0] ext_s1_reg, ext_s2_reg;
  logic [vir_pkg::NGPIO-1:0] gpio_s1_reg, gpio_s2_reg, gpio_s3_reg;
  logic [vir_pkg::NGPIO-1:0] gedge_reg, gedge_next;
  logic [vir_pkg::NSRC-1:0] pend, act, irq_cand, fast_cand, fast_hi_cand;
  logic irq_req_reg, irq_req_next, fast_reg, fast_next, fast_hi_reg, fast_hi_next;
  logic [vir_pkg::LVLW-1:0] irq_vec_reg, irq_vec_next;
  logic [vir_pkg::SRCW-1:0] irq_src_reg, irq_src_next, fast_src_reg, fast_src_next;
  logic rise, fall, det, lv;
  vir_pkg::vir_gmode_t mode;

  vir_prio_if irq_p ();
  vir_prio_if fast_p ();

  vir_prio u_irq_prio (
    .p (irq_p.enc)
  );

  vir_prio u_fast_prio (
    .p (fast_p.enc)
  );

  // Pins are asynchronous; two stages before any logic reads them
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ext_s1_reg <= vir_pkg::EXT_RST;
      ext_s2_reg <= vir_pkg::EXT_RST;
      gpio_s1_reg <= vir_pkg::GPIO_RST;
      gpio_s2_reg <= vir_pkg::GPIO_RST;
      gpio_s3_reg <= vir_pkg::GPIO_RST;
    end else begin
      ext_s1_reg <= ext_irq;
      ext_s2_reg <= ext_s1_reg;
      gpio_s1_reg <= gpio_in;
      gpio_s2_reg <= gpio_s1_reg;
      gpio_s3_reg <= gpio_s2_reg;
    end
  end

  // Source conditioning
  always_comb begin
    pend = periph_irq ^ src_active_low;
    for (int e = 0; e < vir_pkg::NEXT; e++) begin
      pend[vir_pkg::EXT_IDX[e]] = ext_s2_reg[e];
    end
    gedge_next = gedge_reg & ~gpio_ack;
    rise = 1'b0;
    fall = 1'b0;
    det = 1'b0;
    lv = 1'b0;
    mode = vir_pkg::VIR_LVL_HI;
    for (int g = 0; g < vir_pkg::NGPIO; g++) begin
      mode = vir_pkg::vir_gmode_t'(gpio_mode[g]);
      rise = gpio_s2_reg[g] & ~gpio_s3_reg[g];
      fall = ~gpio_s2_reg[g] & gpio_s3_reg[g];
      case (mode)
        vir_pkg::VIR_LVL_HI: begin
          det = 1'b0;
          lv = gpio_s2_reg[g];
        end
        vir_pkg::VIR_LVL_LO: begin
          det = 1'b0;
          lv = ~gpio_s2_reg[g];
        end
        vir_pkg::VIR_RISE: begin
          det = rise;
          lv = gedge_reg[g];
        end
        vir_pkg::VIR_FALL: begin
          det = fall;
          lv = gedge_reg[g];
        end
        vir_pkg::VIR_BOTH: begin
          det = rise | fall;
          lv = gedge_reg[g];
        end
        default: begin
          det = 1'b0;
          lv = 1'b0;
        end
      endcase
      // A new edge in the acknowledge cycle is kept
      gedge_next[g] = gedge_next[g] | (det & gpio_int_en[g]);
      pend[vir_pkg::GPIO_BASE + g] = gpio_int_en[g] & lv;
    end
  end

  // Routing, masking and resolution
  always_comb begin
    act = pend & src_enable;
    irq_cand = '0;
    fast_cand = '0;
    for (int i = 0; i < vir_pkg::NSRC; i++) begin
      irq_cand[i] = act[i] & ~route_fast[i] &
                    ({1'b0, vir_pkg::irq_level(i[vir_pkg::SRCW-1:0])} < irq_mask_level);
      fast_cand[i] = act[i] & route_fast[i] &
                     (fast_prio_hi[i] ? (fast_mask_level >= vir_pkg::FAST_MASK_HI)
                                      : (fast_mask_level >= vir_pkg::FAST_MASK_ALL));
    end
    fast_hi_cand = fast_cand & fast_prio_hi;
    irq_p.req = irq_cand;
    // High fast level beats low fast level regardless of source number
    fast_p.req = (|fast_hi_cand) ? fast_hi_cand : fast_cand;
    irq_req_next = irq_p.hit;
    irq_src_next = irq_p.idx;
    irq_vec_next = vir_pkg::irq_level(irq_p.idx);
    fast_next = fast_p.hit;
    fast_src_next = fast_p.idx;
    fast_hi_next = |fast_hi_cand;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gedge_reg <= vir_pkg::GPIO_RST;
      irq_req_reg <= 1'b0;
      irq_vec_reg <= vir_pkg::LVL_RST;
      irq_src_reg <= vir_pkg::IDX_RST;
      fast_reg <= 1'b0;
      fast_hi_reg <= 1'b0;
      fast_src_reg <= vir_pkg::IDX_RST;
    end else begin
      gedge_reg <= gedge_next;
      irq_req_reg <= irq_req_next;
      irq_vec_reg <= irq_vec_next;
      irq_src_reg <= irq_src_next;
      fast_reg <= fast_next;
      fast_hi_reg <= fast_hi_next;
      fast_src_reg <= fast_src_next;
    end
  end

  assign irq_req = irq_req_reg;
  assign irq_vector = irq_vec_reg;
  assign irq_source = irq_src_reg;
  assign fast_interrupt_request = fast_reg;
  assign fast_high = fast_hi_reg;
  assign fast_source = fast_src_reg;
  assign gpio_edge_pending = gedge_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  route_excl_a: assert property (irq_req_reg && fast_reg |-> irq_src_reg != fast_src_reg)
    else $error("source routed to both requests");
  irq_level_a: assert property (irq_req_reg |-> irq_vec_reg == vir_pkg::irq_level(irq_src_reg))
    else $error("normal vector does not match source level");
  irq_mask_a: assert property (irq_req_reg |-> {1'b0, irq_vec_reg} < $past(irq_mask_level))
    else $error("masked normal request reached core");
  fast_mask_a: assert property (fast_reg |-> $past(fast_mask_level) != 2'h0)
    else $error("fast request passed a closed mask");
  int_level_a: assert property (src_enable[19] && !route_fast[19] && irq_mask_level == vir_pkg::IRQ_MASK_OPEN &&
                                (periph_irq[19] ^ src_active_low[19]) |=> irq_req_reg)
    else $error("internal level source not requested");
  gpio_rise_a: assert property (gpio_int_en[3] && gpio_mode[3] == vir_pkg::VIR_RISE &&
                                gpio_s2_reg[3] && !gpio_s3_reg[3] |=> gedge_reg[3])
    else $error("rising edge not latched");
  ext_line_a: assert property (src_enable[22] && !route_fast[22] && irq_mask_level == vir_pkg::IRQ_MASK_OPEN &&
                               ext_irq[0] [*3] |=> irq_req_reg)
    else $error("external line 22 not requested");
  gpio_off_a: assert property (!gpio_int_en[0] |-> !pend[vir_pkg::GPIO_BASE])
    else $error("disabled gpio still pending");
  edge_hold_a: assert property (&(~$past(gedge_reg) | $past(gpio_ack) | gedge_reg))
    else $error("edge latch dropped without acknowledge");
  fast_cause_a: assert property (fast_reg |-> $past(|(src_enable & route_fast)))
    else $error("fast request without a routed source");
endmodule
